// >>> hw/ftm_engine.sv
// Frame toggle modulation engine: pixel stream in, lit bits out
// Assumes pixel port and frame pulse come from logic on clk
//
// Notes on behaviour
// (RQ1) Red, green, blue each get their own lit decision, refreshed per frame.
// (RQ2) A sequence is 64 bits; a set bit lights the component that frame.
// (RQ3) After position 63 the position returns to 0 and repeats.
// (RQ4) Each pixel carries a 6-bit intensity per colour component.
// (RQ5) Each 6-bit intensity is dithered down to 5 bits first.
// (RQ6) The 5-bit value picks one of 32 stored sequences per component.
// (RQ7) The programmer loads a 64-bit pattern for every one of 32 values.
// (RQ8) Lit share over 64 frames equals set bits of the sequence over 64.
// (RQ9) Programmer favours many zero-to-one transitions to avoid flicker.
// (RQ10) Programmer keeps lit shares within 16/64 to 48/64, except ends.
// (RQ11) Example table: values 0,1 all dark; value 4 repeats 0001.
// (RQ12) Pixel port is 18 bits, six per colour.
// (RQ13) While panel output is enabled, writes are ignored, reads undefined.
// (RQ14) One shared 6-bit frame counter advances at each frame boundary.
// (RQ15) Each component has a 32 by 64-bit store, row by value, bit by frame.
`timescale 1ns/1ps
`include "ftm_consts.svh"
module ftm_engine
(
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // Control
   input  wire logic                       panel_output_enable,
   input  wire logic                       frame_start,
   // Pixel port, red in 17:12, green 11:6, blue 5:0
   input  wire logic                       pix_valid,
   output      logic                       pix_ready,
   input  wire logic [`FTM_PIX_W-1:0]      pix_data,
   // Panel side, bit 2 red, 1 green, 0 blue
   output      logic                       out_valid,
   input  wire logic                       out_ready,
   output      logic [`FTM_COLOURS-1:0]    out_rgb,
   // Sequence store port, select 0 blue, 1 green, 2 red
   input  wire logic                       mem_wr,
   input  wire logic                       mem_rd,
   input  wire logic [`FTM_SEL_W-1:0]      mem_sel,
   input  wire logic [`FTM_IDX_W-1:0]      mem_row,
   input  wire logic [`FTM_SEQ_LEN-1:0]    mem_wdata,
   output      logic                       mem_rvalid,
   output      logic [`FTM_SEQ_LEN-1:0]    mem_rdata
);
   ftm_pkg::ftm_state_s                       s_q;
   ftm_pkg::ftm_state_s                       s_d;
   logic                                      f_valid;
   logic                                      f_ready;
   logic [`FTM_PIX_W-1:0]                     f_data;
   logic                                      take;
   logic [`FTM_COLOURS-1:0]                   lit;
   logic [`FTM_COLOURS-1:0][`FTM_IDX_W-1:0]   dith;

   ////////////////////////////////////////////////////////////////////////
   // Input buffer, back-pressure reaches pix_ready
   ftm_fifo #(.WIDTH(`FTM_PIX_W), .DEPTH(`FTM_FIFO_DEPTH)) u_fifo
   (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (pix_valid),
      .in_ready  (pix_ready),
      .in_data   (pix_data), // RQ12 RQ4
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Per component dither and sequence lookup
   generate
      for (genvar c = 0; c < `FTM_COLOURS; c++)
      begin : g_comp
         logic [`FTM_COMP_W-1:0] comp;
         logic [`FTM_COMP_W-1:0] sum;
         assign comp = f_data[c*`FTM_COMP_W +: `FTM_COMP_W];
         // Round up on odd frames for odd inputs, saturating
         assign sum = {1'b0, comp[`FTM_COMP_W-1:1]}
                    + {5'h00, comp[0] & s_q.frame[0]}; // RQ5
         assign dith[c] = sum[`FTM_IDX_W] ? 5'h1F
                        : sum[`FTM_IDX_W-1:0];
         // Row by value, bit by frame position
         assign lit[c] = s_q.mem[c][dith[c]][s_q.frame]; // RQ6 RQ15 RQ2
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Outputs from state
   assign take       = f_valid && (!s_q.out_valid || out_ready);
   assign f_ready    = take;
   assign out_valid  = s_q.out_valid;
   assign out_rgb    = s_q.out_rgb;
   assign mem_rvalid = s_q.rvalid;
   assign mem_rdata  = s_q.rdata;

   // Next state: frame count, store, output stage, read port
   always_comb
   begin
      s_d = s_q;
      if (frame_start)
         s_d.frame = s_q.frame + 6'h01; // RQ14 RQ3
      if (mem_wr && !panel_output_enable && mem_sel != `FTM_SEL_NONE)
         s_d.mem[mem_sel][mem_row] = mem_wdata; // RQ13 RQ15
      s_d.rvalid = mem_rd;
      if (panel_output_enable || mem_sel == `FTM_SEL_NONE)
         s_d.rdata = 64'h0000000000000000; // RQ13
      else
         s_d.rdata = s_q.mem[mem_sel][mem_row];
      if (take)
      begin
         s_d.out_valid = 1'b1;
         s_d.out_rgb   = lit; // RQ1 RQ8
      end
      else if (out_ready)
         s_d.out_valid = 1'b0;
   end

   // State register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_q       <= '0;
         s_q.frame <= `FTM_FRAME_RST;
      end
      else
         s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence seq_take;
      f_valid && (!s_q.out_valid || out_ready);
   endsequence

   sequence seq_wr_open;
      mem_wr && !panel_output_enable && mem_sel != `FTM_SEL_NONE;
   endsequence

   AST_FRAME_ADV: assert property (@(posedge clk) disable iff (rst) // RQ14
      frame_start |=> s_q.frame == $past(s_q.frame) + 6'h01)
      else $error("frame count did not advance");

   AST_FRAME_HOLD: assert property (@(posedge clk) disable iff (rst) // RQ1
      !frame_start |=> $stable(s_q.frame))
      else $error("frame count moved inside a frame");

   AST_WRAP: assert property (@(posedge clk) disable iff (rst) // RQ3
      frame_start && s_q.frame == 6'h3F |=> s_q.frame == 6'h00)
      else $error("frame count did not wrap");

   AST_WR_BLOCK: assert property (@(posedge clk) disable iff (rst) // RQ13
      mem_wr && panel_output_enable |=> $stable(s_q.mem))
      else $error("store changed while panel enabled");

   AST_WR_TAKE: assert property (@(posedge clk) disable iff (rst) // RQ15
      seq_wr_open |=> s_q.mem[$past(mem_sel)][$past(mem_row)]
                      == $past(mem_wdata))
      else $error("store write lost");

   AST_LIT_RED: assert property (@(posedge clk) disable iff (rst) // RQ6
      seq_take |=> out_valid && out_rgb[2]
         == $past(s_q.mem[2][dith[2]][s_q.frame]))
      else $error("red lit bit wrong");

   AST_LIT_BLUE: assert property (@(posedge clk) disable iff (rst) // RQ8
      seq_take |=> out_rgb[0] == $past(s_q.mem[0][dith[0]][s_q.frame]))
      else $error("blue lit bit wrong");

   AST_DITHER: assert property (@(posedge clk) disable iff (rst) // RQ5
      seq_take and (f_data[6] == 1'b0) |-> dith[1] == f_data[11:7])
      else $error("even intensity not halved");

   AST_OUT_HOLD: assert property (@(posedge clk) disable iff (rst) // RQ1
      out_valid && !out_ready |=> out_valid && $stable(out_rgb))
      else $error("output dropped under stall");

   AST_RD_LOCK: assert property (@(posedge clk) disable iff (rst) // RQ13
      mem_rd && panel_output_enable |=> mem_rvalid
         && mem_rdata == 64'h0000000000000000)
      else $error("store readable while enabled");
endmodule : ftm_engine

// >>> shared/ftm_consts.svh
// Constants of the frame toggle modulation engine
// Assumes inclusion by bare name from package and modules
`ifndef FTM_CONSTS_SVH
`define FTM_CONSTS_SVH
`define FTM_SEQ_LEN    64
`define FTM_SEQ_ROWS   32
`define FTM_COLOURS    3
`define FTM_COMP_W     6
`define FTM_IDX_W      5
`define FTM_FRAME_W    6
`define FTM_SEL_W      2
`define FTM_PIX_W      18
`define FTM_FIFO_DEPTH 4
`define FTM_FRAME_RST  6'h00
`define FTM_SEL_NONE   2'h3
`endif

// >>> shared/ftm_pkg.sv
// Types of the frame toggle modulation engine
// Assumes ftm_consts.svh on the include path
`include "ftm_consts.svh"
package ftm_pkg;
   typedef logic [`FTM_SEQ_LEN-1:0] ftm_seq_t;
   typedef struct packed {
      logic [`FTM_COLOURS-1:0][`FTM_SEQ_ROWS-1:0][`FTM_SEQ_LEN-1:0] mem;
      logic [`FTM_FRAME_W-1:0]  frame;
      logic                     out_valid;
      logic [`FTM_COLOURS-1:0]  out_rgb;
      logic                     rvalid;
      logic [`FTM_SEQ_LEN-1:0]  rdata;
   } ftm_state_s;
endpackage : ftm_pkg

// >>> hw/ftm_fifo.sv
// Small flop FIFO with valid and ready on both sides
// Assumes DEPTH is a power of two, single clock
`timescale 1ns/1ps
module ftm_fifo
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 4
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wp;
      logic [PW-1:0]               rp;
      logic [PW:0]                 cnt;
   } ftm_fifo_s;

   ftm_fifo_s s_q;
   ftm_fifo_s s_d;
   logic      push;
   logic      pop;

   ////////////////////////////////////////////////////////////////////////
   // Handshakes from the fill level
   assign in_ready  = (s_q.cnt != (PW+1)'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign out_data  = s_q.mem[s_q.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Next state of storage and pointers
   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp          = s_q.wp + PW'(1);
      end
      if (pop)
         s_d.rp = s_q.rp + PW'(1);
      s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end

   // State register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule : ftm_fifo

// >>> sim/ftm_pix_src.sv
// Pixel source standing in for the graphics processor
// Assumes one clock shared with the engine
`timescale 1ns/1ps
`include "ftm_consts.svh"
module ftm_pix_src
(
   // Clock
   input  wire logic                  clk,
   // Pixel port
   output      logic                  pix_valid,
   input  wire logic                  pix_ready,
   output      logic [`FTM_PIX_W-1:0] pix_data
);
   // Idle bus
   initial
   begin
      pix_valid = 1'b0;
      pix_data  = 18'h2AAAA;
   end

   // Offer a pixel until taken; keep holds valid up
   task automatic send(input logic [`FTM_PIX_W-1:0] d, input bit keep);
      pix_valid <= 1'b1;
      pix_data  <= d;
      do
         @(posedge clk);
      while (pix_ready !== 1'b1);
      if (!keep)
      begin
         pix_valid <= 1'b0;
         pix_data  <= ~d;
      end
   endtask : send
endmodule : ftm_pix_src

// >>> sim/frame_rate_modulation_engine_test.sv
// Testbench of the engine with scoreboards
// Assumes ftm_engine and ftm_pix_src compiled first
`timescale 1ns/1ps
`include "ftm_consts.svh"
module frame_rate_modulation_engine_test;
   logic        clk, rst, en, fs, pv, pr, ov, ordy, wr, rd, rv, rd_d, full;
   logic [17:0] pd, p;
   logic [2:0]  rgb;
   logic [1:0]  sel;
   logic [4:0]  row;
   logic [5:0]  fr;
   logic [63:0] wd, rdat;
   logic [63:0] sm [3][32];
   logic [63:0] rq [$];
   logic [2:0]  pq [$];
   int          mismatches, samples_checked, cyc, hold;
   bit          k;

   ftm_engine dut_u (.clk(clk), .rst(rst), .panel_output_enable(en),
      .frame_start(fs), .pix_valid(pv), .pix_ready(pr), .pix_data(pd),
      .out_valid(ov), .out_ready(ordy), .out_rgb(rgb), .mem_wr(wr),
      .mem_rd(rd), .mem_sel(sel), .mem_row(row), .mem_wdata(wd),
      .mem_rvalid(rv), .mem_rdata(rdat));
   ftm_pix_src src_u (.clk(clk), .pix_valid(pv), .pix_ready(pr),
      .pix_data(pd));

   ////////////////////////////////////////////////////////////////////
   task automatic check(input string n, input logic [63:0] s, e);
      samples_checked++;
      if (s !== e)
      begin
         mismatches++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask : check

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   // Store write or read, noting the read answer
   task automatic acc(input bit w, input logic [1:0] s, input logic [4:0] r,
                      input logic [63:0] d);
      @(posedge clk);
      wr  <= w;
      rd  <= !w;
      sel <= s;
      row <= r;
      wd  <= d;
      if (!w)
         rq.push_back((en || s == 2'h3) ? 64'h0 : sm[s][r]);
      else if (!en && s != 2'h3)
         sm[s][r] = d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      wd <= ~d;
   endtask : acc

   // Expected lit bits of one pixel
   function automatic logic [2:0] lit(input logic [17:0] x);
      logic [6:0] d;
      for (int c = 0; c < 3; c++)
      begin
         d = 7'(x[6*c+1 +: 5]) + 7'(x[6*c] & fr[0]);
         if (d > 7'h1F)
            d = 7'h1F;
         lit[c] = sm[c][d[4:0]][fr];
      end
   endfunction : lit

   // Clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Panel stalls, cycle count and both scoreboards
   always @(posedge clk)
   begin
      cyc++;
      ordy <= (cyc < hold) ? 1'b0 : 1'(($urandom % 4) != 0);
      full <= full | (pr === 1'b0);
      if (rd_d === 1'b1 || rv === 1'b1)
         check("rvalid", 64'(rv), 64'(rd_d));
      if (rv === 1'b1)
         check("rdata", rdat, rq.size() ? rq.pop_front() : ~rdat);
      rd_d <= rd;
      if (ov === 1'b1 && ordy === 1'b1)
         check("rgb", 64'(rgb),
               pq.size() ? 64'(pq.pop_front()) : 64'hF);
   end

   // Main sequence
   initial
   begin
      {rst, en, fs, ordy, wr, rd, rd_d, full, sel, row, wd, fr} = 'h0;
      // Store model starts all dark, as the store does after reset
      foreach (sm[i, j])
         sm[i][j] = 64'h0000000000000000;
      rst = 1'b1;
      hold = 0;
      void'($urandom(32'h8156));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      acc(0, 2'h2, 5'h1F, 0);
      for (int c = 0; c < 3; c++)
         for (int r = 0; r < 32; r++)
            acc(1, 2'(c), 5'(r), r == 4 ? 64'h8888888888888888 :
                r == 31 ? 64'h5555555555555555 :
                r < 2 ? 64'h0 : {$urandom, $urandom});
      acc(1, 2'h3, 5'h2, 64'h5);
      acc(0, 2'h3, 5'h2, 0);
      acc(0, 2'h1, 5'h4, 0);
      en <= 1'b1;
      acc(1, 2'h0, 5'h4, 64'h1);
      acc(0, 2'h0, 5'h4, 0);
      for (int f = 0; f < 66; f++)
      begin
         if (f == 5)
            hold = cyc + 40;
         for (int i = 0; i < (f == 5 ? 8 : 3); i++)
         begin
            p = 18'($urandom);
            k = ($urandom % 2) && i < 2;
            pq.push_back(lit(p));
            src_u.send(p, k);
            if (!k)
               repeat (1 + $urandom % 2) @(posedge clk);
         end
         for (int n = 0; n < 200 && pq.size() != 0; n++)
            @(posedge clk);
         @(posedge clk);
         fs <= 1'b1;
         @(posedge clk);
         fs <= 1'b0;
         fr = fr + 6'h1;
      end
      check("full", 64'(full), 64'h1);
      en <= 1'b0;
      acc(0, 2'h0, 5'h4, 0);
      repeat (3) @(posedge clk);
      check("left", 64'(pq.size() + rq.size()), 64'h0);
      end_of_test();
   end

   // Watchdog
   initial
   begin
      repeat (60000) @(posedge clk);
      mismatches++;
      end_of_test();
   end
endmodule : frame_rate_modulation_engine_test
